/* temp_sensor_consts.vh */
// constants shared by the temperature sensor bus slave and its converter sequencer
// assumes a single 250 MHz core clock and a host-driven two-wire serial bus
`ifndef TEMP_SENSOR_CONSTS_VH
`define TEMP_SENSOR_CONSTS_VH

// ----------------------------------------------------------------
// bus address
// ----------------------------------------------------------------
`define ADDR_FIXED_HI      4'h9
`define ADDR_WIDTH         7

// ----------------------------------------------------------------
// register pointer codes (low two pointer bits)
// ----------------------------------------------------------------
`define PTR_AMBIENT        2'h0
`define PTR_CONFIG         2'h1
`define PTR_HYST           2'h2
`define PTR_LIMIT          2'h3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LIMIT_RESET        9'h0A0
`define HYST_RESET         9'h096
`define CONFIG_RESET       8'h00
`define AMBIENT_RESET      16'h0000

// ----------------------------------------------------------------
// configuration fields
// ----------------------------------------------------------------
`define CFG_SHUTDOWN_BIT   0
`define CFG_RES_LSB        5
`define CFG_RES_MSB        6

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_KHZ            250000
`define CONV_9BIT_MS       30
`define CONV_9BIT_CYCLES   (`CONV_9BIT_MS * `CLK_KHZ)

`endif

/* conv_sequencer.v */
// converter sequencer: paces back-to-back conversions and delivers masked results
// assumes sample_in is the converter's raw 12-bit two's-complement word on clk
`timescale 1ns/1ns
`default_nettype none
`include "temp_sensor_consts.vh"

module conv_sequencer #(
    parameter [31:0] BASE_CYCLES = `CONV_9BIT_CYCLES
) (
    input  wire        clk,
    input  wire        rst_b,
    input  wire        run,
    input  wire [1:0]  resolution,
    input  wire [11:0] sample_in,
    output reg         done,
    output reg  [15:0] result
);

    // ----------------------------------------------------------------
    // conversion timer
    // ----------------------------------------------------------------
    reg  [31:0] count;
    wire [31:0] conv_len = BASE_CYCLES << resolution; // doubles per extra bit
    wire [11:0] res_mask = ~(12'h0007 >> resolution);  // clears unused low bits

    // timer restarts after each result so conversions run back to back
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count  <= 32'h0000_0000;
            done   <= 1'b0;
            result <= `AMBIENT_RESET;
        end else begin
            done <= 1'b0;
            if (!run) begin
                count <= 32'h0000_0000; // shutdown: no conversion in flight
            end else if (count >= conv_len - 32'h0000_0001) begin
                count  <= 32'h0000_0000;
                done   <= 1'b1;
                result <= {sample_in & res_mask, 4'h0};
            end else begin
                count <= count + 32'h0000_0001;
            end
        end
    end

endmodule
`default_nettype wire

/* temp_sensor_bus_slave.v */
// temperature sensor digital side: two-wire slave, register file and alert logic
// assumes pins arrive asynchronously and an external pull-up on data and alert lines
//
// Behaviour
// - address is 1001 followed by the three address-select pin levels.
// - all bus timing follows the host bus clock edges.
// - data line is bidirectional, device only pulls low or releases.
// - alert pin is open-drain, never driven high.
// - alert signals when temperature rises above limit-set, and clears only when it falls below hysteresis.
// - resolution selectable 9 to 12 bits; 30 ms up to 240 ms.
// - exactly four registers: ambient, limit-set, hysteresis, configuration.
// - ambient register is read-only; host writes leave it unchanged.
// - each result loads the ambient register whole, in parallel.
// - limit-set and hysteresis are host readable and writable thresholds.
// - 8-bit pointer, low two bits select the register.
// - ambient reads 16-bit two's complement, unused low bits zero.
// - limit-set powers up as 80 degrees, 0 1010 0000.
`timescale 1ns/1ns
`default_nettype none
`include "temp_sensor_consts.vh"

module temp_sensor_bus_slave #(
    parameter [31:0] CONV_BASE_CYCLES = `CONV_9BIT_CYCLES
) (
    input  wire        clk,
    input  wire        rst_b,
    input  wire        bus_clk_pin,
    input  wire        sda_in,
    output reg         sda_out,
    output reg         sda_oe,
    input  wire        addr_select_hi,
    input  wire        addr_select_mid,
    input  wire        addr_select_lo,
    output reg         alert_out,
    output reg         alert_oe,
    input  wire [11:0] sample_in
);

    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    localparam [6:0] ST_IDLE = 7'b000_0001;
    localparam [6:0] ST_ADDR = 7'b000_0010;
    localparam [6:0] ST_AACK = 7'b000_0100;
    localparam [6:0] ST_RX   = 7'b000_1000;
    localparam [6:0] ST_WACK = 7'b001_0000;
    localparam [6:0] ST_TX   = 7'b010_0000;
    localparam [6:0] ST_MACK = 7'b100_0000;

    // signed compare of two 9-bit temperatures
    function gt9;
        input [8:0] a;
        input [8:0] b;
        begin
            gt9 = $signed(a) > $signed(b);
        end
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    reg [4:0] sync1;
    reg [4:0] sync2;
    reg       scl_d;
    reg       sda_d;

    // first stage feeds only the second; edges are found on the second
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1 <= 5'h1F;
            sync2 <= 5'h1F;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            sync1 <= {bus_clk_pin, sda_in, addr_select_hi, addr_select_mid, addr_select_lo};
            sync2 <= sync1;
            scl_d <= sync2[4];
            sda_d <= sync2[3];
        end
    end

    wire scl      = sync2[4];
    wire sda      = sync2[3];
    wire scl_rise = scl & ~scl_d;
    wire scl_fall = ~scl & scl_d;
    wire start_c  = scl & scl_d & sda_d & ~sda;
    wire stop_c   = scl & scl_d & ~sda_d & sda;
    wire [6:0] own_addr = {`ADDR_FIXED_HI, sync2[2:0]};

    // ----------------------------------------------------------------
    // registers and converter
    // ----------------------------------------------------------------
    reg  [15:0] ambient;
    reg  [8:0]  limit_set_reg;
    reg  [8:0]  hysteresis_limit_reg;
    reg  [7:0]  config_reg;
    wire        conv_done;
    wire [15:0] conv_result;

    conv_sequencer #(
        .BASE_CYCLES (CONV_BASE_CYCLES)
    ) u_conv (
        .clk        (clk),
        .rst_b      (rst_b),
        .run        (~config_reg[`CFG_SHUTDOWN_BIT]),
        .resolution (config_reg[`CFG_RES_MSB:`CFG_RES_LSB]),
        .sample_in  (sample_in),
        .done       (conv_done),
        .result     (conv_result)
    );

    // ----------------------------------------------------------------
    // bus engine
    // ----------------------------------------------------------------
    reg [6:0]  state;
    reg [2:0]  bit_cnt;
    reg [7:0]  shift;
    reg [15:0] tx_word;
    reg        tx_lo;
    reg        rw;
    reg [1:0]  pointer;
    reg [1:0]  byte_idx;
    reg [7:0]  hi_byte;
    reg        addr_full; // eight address bits taken since the last start

    // live read word mux; config repeats in both bytes
    reg [15:0] rd_word;
    always @* begin
        case (pointer)
            `PTR_AMBIENT: rd_word = ambient;
            `PTR_CONFIG:  rd_word = {config_reg, config_reg};
            `PTR_HYST:    rd_word = {hysteresis_limit_reg, 7'h00};
            default:      rd_word = {limit_set_reg, 7'h00};
        endcase
    end

    wire [7:0] rx_byte = {shift[6:0], sda};

    // protocol walk: sample on rising bus clock, change data on falling
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state                <= ST_IDLE;
            bit_cnt              <= 3'h0;
            shift                <= 8'h00;
            tx_word              <= 16'h0000;
            tx_lo                <= 1'b0;
            rw                   <= 1'b0;
            pointer              <= `PTR_AMBIENT;
            byte_idx             <= 2'h0;
            hi_byte              <= 8'h00;
            addr_full            <= 1'b0;
            sda_out              <= 1'b0;
            sda_oe               <= 1'b0;
            limit_set_reg        <= `LIMIT_RESET;
            hysteresis_limit_reg <= `HYST_RESET;
            config_reg           <= `CONFIG_RESET;
        end else if (start_c) begin
            state     <= ST_ADDR; // repeated start restarts addressing
            bit_cnt   <= 3'h0;
            addr_full <= 1'b0;
            sda_oe  <= 1'b0;
        end else if (stop_c) begin
            state  <= ST_IDLE;
            sda_oe <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    sda_oe <= 1'b0;
                end
                ST_ADDR: begin
                    if (scl_rise) begin
                        shift     <= rx_byte;
                        bit_cnt   <= bit_cnt + 3'h1;
                        addr_full <= (bit_cnt == 3'h7);
                    end else if (scl_fall && addr_full) begin
                        // the clock fall that ends the start holds no address bits
                        // eight bits taken; acknowledge only our own address
                        if (shift[7:1] == own_addr) begin
                            sda_oe <= 1'b1;
                            rw     <= shift[0];
                            state  <= ST_AACK;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_AACK: begin
                    if (scl_fall) begin
                        byte_idx <= 2'h0;
                        bit_cnt  <= 3'h0;
                        if (rw) begin
                            // high byte captured now; the low byte is reloaded from rd_word at the host acknowledge
                            tx_word <= {rd_word[14:0], 1'b0};
                            shift   <= rd_word[15:8];
                            tx_lo   <= 1'b1;
                            sda_oe  <= ~rd_word[15];
                            state   <= ST_TX;
                        end else begin
                            sda_oe <= 1'b0;
                            state  <= ST_RX;
                        end
                    end
                end
                ST_RX: begin
                    if (scl_rise) begin
                        shift   <= rx_byte;
                        bit_cnt <= bit_cnt + 3'h1;
                    end else if (scl_fall && bit_cnt == 3'h0) begin
                        sda_oe <= 1'b1;
                        state  <= ST_WACK;
                        if (byte_idx == 2'h0) begin
                            pointer <= shift[1:0];
                        end else if (pointer == `PTR_CONFIG) begin
                            config_reg <= shift;
                        end else if (byte_idx == 2'h1) begin
                            hi_byte <= shift;
                        end else if (pointer == `PTR_LIMIT) begin
                            limit_set_reg <= {hi_byte, shift[7]};
                        end else if (pointer == `PTR_HYST) begin
                            hysteresis_limit_reg <= {hi_byte, shift[7]};
                        end
                        // ambient pointer: data bytes are dropped
                        if (byte_idx != 2'h2) begin
                            byte_idx <= byte_idx + 2'h1;
                        end else begin
                            byte_idx <= 2'h1;
                        end
                    end
                end
                ST_WACK: begin
                    if (scl_fall) begin
                        sda_oe <= 1'b0;
                        state  <= ST_RX;
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt == 3'h7) begin
                            sda_oe <= 1'b0; // release for host acknowledge
                            state  <= ST_MACK;
                        end else begin
                            bit_cnt <= bit_cnt + 3'h1;
                            sda_oe  <= ~tx_word[15];
                            tx_word <= {tx_word[14:0], 1'b0};
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise && sda) begin
                        state <= ST_IDLE; // host nack ends the read
                    end else if (scl_fall) begin
                        // bytes alternate high, low; each byte reloads from the current rd_word
                        tx_word <= tx_lo ? {rd_word[6:0], 9'h000} :
                                           {rd_word[14:0], 1'b0};
                        sda_oe  <= tx_lo ? ~rd_word[7] : ~rd_word[15];
                        tx_lo   <= ~tx_lo;
                        bit_cnt <= 3'h0;
                        state   <= ST_TX;
                    end
                end
                default: begin
                    state  <= ST_IDLE;
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // ambient register and alert comparator
    // ----------------------------------------------------------------
    // comparator with hysteresis: set above limit, clear below hysteresis
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ambient   <= `AMBIENT_RESET;
            alert_out <= 1'b0;
            alert_oe  <= 1'b0;
        end else begin
            alert_out <= 1'b0;
            if (conv_done) begin
                ambient <= conv_result;
                if (gt9(conv_result[15:7], limit_set_reg)) begin
                    alert_oe <= 1'b1;
                end else if (gt9(hysteresis_limit_reg, conv_result[15:7])) begin
                    alert_oe <= 1'b0;
                end
            end
        end
    end

endmodule
`default_nettype wire

/* temp_sensor_bus_slave_assertions.sv */
// checker for the sensor bus slave: open-drain drive, bus timing, alert causes
// assumes binding to the top module and a bus clock half period above 8 clk
`timescale 1ns/1ns
`default_nettype none
module temp_sensor_bus_slave_chk #(
    parameter [31:0] CONV_BASE_CYCLES = 32'h0000_0032
) (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        bus_clk_pin,
    input wire logic        sda_out,
    input wire logic        sda_oe,
    input wire logic        alert_out,
    input wire logic        alert_oe,
    input wire logic [11:0] sample_in
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ----------------------------------------
    // clocks since the bus clock went low
    // ----------------------------------------
    // the pin is synchronised, so the data line moves a few clocks late
    logic [3:0] low_cnt;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            low_cnt <= 4'h0;
        end else if (bus_clk_pin) begin
            low_cnt <= 4'h0;
        end else if (low_cnt != 4'hf) begin
            low_cnt <= low_cnt + 4'h1;
        end
    end
    sequence drive_at_rise;
        sda_oe ##0 $rose(bus_clk_pin);
    endsequence
    sequence hold_eight;
        sda_oe [*8];
    endsequence
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    sda_out_low_a: assert property (sda_out == 1'b0)
        else $error("data drive value not low");
    alert_out_low_a: assert property (alert_out == 1'b0)
        else $error("alert drive value not low");
    oe_change_timing_a: assert property ($changed(sda_oe) |->
        !bus_clk_pin && low_cnt inside {[4'h2:4'h7]}) else $error("data line moved off timing");
    scl_high_stable_a: assert property (bus_clk_pin [*4] |-> $stable(sda_oe))
        else $error("data line moved while bus clock high");
    ack_hold_a: assert property ($rose(sda_oe) |-> hold_eight)
        else $error("device drive dropped too soon");
    drive_over_high_a: assert property (drive_at_rise |-> hold_eight)
        else $error("device drive dropped in clock high");
    // the sample behind an alert change was taken two clocks before it is seen
    alert_rise_cause_a: assert property ($rose(alert_oe) |->
        $signed($past(sample_in[11:3], 2)) > $signed(9'h0a0))
        else $error("alert without high sample");
    alert_fall_cause_a: assert property ($fell(alert_oe) |->
        $signed($past(sample_in[11:3], 2)) < $signed(9'h096))
        else $error("alert cleared above hysteresis");
endmodule
bind temp_sensor_bus_slave temp_sensor_bus_slave_chk #(
    .CONV_BASE_CYCLES(CONV_BASE_CYCLES)
) chk (
    .clk(clk), .rst_b(rst_b), .bus_clk_pin(bus_clk_pin), .sda_out(sda_out),
    .sda_oe(sda_oe), .alert_out(alert_out), .alert_oe(alert_oe), .sample_in(sample_in)
);
`default_nettype wire

/* i2c_host_model.sv */
// host controller model: makes the bus clock and pulls the data line
// assumes the bench resolves the pulled-up line; 160 ns bit period
`timescale 1ns/1ns
`default_nettype none
module i2c_host_model (
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda_line
);
    // bus idles high; the clock stands still between frames
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // start or repeated start: data falls while the clock is high
    task automatic start_cond();
        #40 sda_pull = 1'b0;
        #40 scl = 1'b1;
        #40 sda_pull = 1'b1;
        #40 scl = 1'b0;
    endtask
    // stop: data rises while the clock is high
    task automatic stop_cond();
        #40 sda_pull = 1'b1;
        #40 scl = 1'b1;
        #40 sda_pull = 1'b0;
        #80;
    endtask
    // data set mid-low, sampled mid-way through the high phase
    task automatic xbit(input logic b, output logic r);
        #40 sda_pull = !b;
        #40 scl = 1'b1;
        #40 r = sda_line;
        #40 scl = 1'b0;
    endtask
    // byte msb first, then the acknowledge slot
    task automatic xbyte(input logic [7:0] d, input logic ab, output logic [7:0] q,
                         output logic a);
        for (int i = 7; i >= 0; i--) begin
            xbit(d[i], q[i]);
        end
        xbit(ab, a);
    endtask
endmodule
`default_nettype wire

/* test_temp_sensor_bus_slave.sv */
// bench for the sensor bus slave: register traffic, conversions, alert
// assumes the host model and a pull-up on the data line
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
    $display("BAD %s exp %h got %h", nm, e, a); end end
module test_temp_sensor_bus_slave;
    localparam [31:0] BASE = 32'h0000_0032;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [2:0]  sel = 3'h5;
    logic [11:0] sample = 12'h000;
    logic [6:0]  dev = 7'h4d;
    logic [15:0] v;
    int          n_mismatch = 0;
    int          checked = 0;
    wire         scl, pull, sda_oe, sda_out, alert_oe, alert_out;
    // ----------------------------------------
    // clock, pull-up and instances
    // ----------------------------------------
    always #2 clk = ~clk;
    wire         sda_line;
    assign sda_line = !(sda_oe && !sda_out) && !pull;
    i2c_host_model host (.scl(scl), .sda_pull(pull), .sda_line(sda_line));
    temp_sensor_bus_slave #(.CONV_BASE_CYCLES(BASE)) dut (
        .clk(clk), .rst_b(rst_b), .bus_clk_pin(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_hi(sel[2]),
        .addr_select_mid(sel[1]), .addr_select_lo(sel[0]), .alert_out(alert_out),
        .alert_oe(alert_oe), .sample_in(sample));
    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task automatic wr(input logic [7:0] p, input logic [15:0] d, input int n);
        logic [7:0] q;
        logic       a;
        // bus pins move on the falling clock edge, away from the sampling edge
        @(negedge clk);
        host.start_cond();
        host.xbyte({dev, 1'b0}, 1'b1, q, a);
        `CHK("addr ack", 1'b0, a)
        host.xbyte(p, 1'b1, q, a);
        `CHK("ptr ack", 1'b0, a)
        for (int i = 0; i < n; i++) begin
            host.xbyte(i[0] ? d[7:0] : d[15:8], 1'b1, q, a);
            `CHK("data ack", 1'b0, a)
        end
        host.stop_cond();
    endtask
    // point, then read high byte with ack and low byte with nack
    task automatic look(input logic [7:0] p, input logic [15:0] e, input string nm);
        logic a;
        wr(p, 16'h0000, 0);
        @(negedge clk);
        host.start_cond();
        host.xbyte({dev, 1'b1}, 1'b1, v[15:8], a);
        host.xbyte(8'hff, 1'b0, v[15:8], a);
        host.xbyte(8'hff, 1'b1, v[7:0], a);
        host.stop_cond();
        `CHK(nm, e, v)
    endtask
    task automatic set_sample(input logic [11:0] s, input int wait_clk);
        @(posedge clk) sample <= s;
        repeat (wait_clk) @(posedge clk);
        @(negedge clk);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_power_up();
        `CHK("alert idle", 1'b0, alert_oe)
        look(8'h03, 16'h5000, "limit reset");
        look(8'h01, 16'h0000, "config reset");
        $display("test power_up done");
    endtask
    task automatic t_thresholds();
        wr(8'h03, 16'h6400, 2);
        look(8'h03, 16'h6400, "limit");
        wr(8'h02, 16'h4080, 2);
        look(8'h02, 16'h4080, "hysteresis");
        $display("test thresholds done");
    endtask
    task automatic t_ambient();
        set_sample(12'h195, 120);
        look(8'h00, 16'h1900, "ambient 9 bit");
        wr(8'h00, 16'h1234, 2);
        look(8'h00, 16'h1900, "ambient kept");
        wr(8'h01, 16'h6000, 1);
        look(8'h01, 16'h6060, "config");
        repeat (900) @(posedge clk);
        look(8'h00, 16'h1950, "ambient 12 bit");
        wr(8'h01, 16'h0000, 1);
        $display("test ambient done");
    endtask
    // limit is 0x0c8 and hysteresis 0x081 here
    task automatic t_alert();
        set_sample(12'h650, 200);
        `CHK("alert set", 1'b1, alert_oe)
        set_sample(12'h500, 200);
        `CHK("alert held", 1'b1, alert_oe)
        set_sample(12'h3c0, 200);
        `CHK("alert clear", 1'b0, alert_oe)
        $display("test alert done");
    endtask
    task automatic t_foreign();
        logic [7:0] q;
        logic       a;
        @(posedge clk) sel <= 3'h2;
        repeat (10) @(posedge clk);
        @(negedge clk);
        host.start_cond();
        host.xbyte({dev, 1'b0}, 1'b1, q, a);
        `CHK("foreign addr", 1'b1, a)
        host.xbyte(8'h03, 1'b1, q, a);
        `CHK("foreign data", 1'b1, a)
        host.stop_cond();
        dev = 7'h4a;
        look(8'h03, 16'h6400, "new address");
        $display("test foreign done");
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (90000) @(posedge clk);
        n_mismatch++;
        stop_test();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (10) @(posedge clk);
        t_power_up();
        t_thresholds();
        t_ambient();
        t_alert();
        t_foreign();
        stop_test();
    end
endmodule
`default_nettype wire
